// ### verilog/acrb_map.svh
// Purpose: offsets, field positions, masks and default codes of the amplifier control bank
// Assumes: included by the slot selector, the control bank and the bench, which need the numbers
// Notes: definitions only
`ifndef ACRB_MAP_SVH
`define ACRB_MAP_SVH

// register offsets
`define ACRB_ADDR_CTRL 4'h0
`define ACRB_ADDR_SLICE 4'h1
`define ACRB_ADDR_EMPH 4'h2
`define ACRB_ADDR_SWING 4'h3
`define ACRB_ADDR_BW_A 4'h4
`define ACRB_ADDR_LVL_A 4'h8
`define ACRB_ADDR_LAST_RW 4'hB
`define ACRB_ADDR_BW_RPT 4'hE
`define ACRB_ADDR_LVL_RPT 4'hF
`define ACRB_NUM_RW 12

// writable-bit masks, all other bits read zero
`define ACRB_MASK_CTRL 8'h0F
`define ACRB_MASK_SLICE 8'hFF
`define ACRB_MASK_EMPH 8'h0F
`define ACRB_MASK_SWING 8'h03
`define ACRB_MASK_BW 8'h8F
`define ACRB_MASK_LVL 8'hFF

// control bit positions
`define ACRB_BIT_OUT_OFF 3
`define ACRB_BIT_RANGE_HI 2
`define ACRB_BIT_NULL_OFF 1
`define ACRB_BIT_PORT_OFF 0
`define ACRB_BIT_USE_REG 7

// reset and special values
`define ACRB_RESET_BYTE 8'h00
`define ACRB_SLICE_ZERO 8'h80

// fixed slot codes, standing for 2.2, 4.0, 6.5, 11.0 GHz
`define ACRB_BW_DEF_A 4'h0
`define ACRB_BW_DEF_B 4'h5
`define ACRB_BW_DEF_C 4'hA
`define ACRB_BW_DEF_D 4'hF
// fixed level codes, standing for 15, 18, 26 and 26 mVpp
`define ACRB_LVL_DEF_A 7'h0F
`define ACRB_LVL_DEF_B 7'h12
`define ACRB_LVL_DEF_CD 7'h1A

// emphasis codes for 1 to 8 dB
`define ACRB_EMPH_1DB 4'h1
`define ACRB_EMPH_2DB 4'h3
`define ACRB_EMPH_3DB 4'h4
`define ACRB_EMPH_4DB 4'h5
`define ACRB_EMPH_5DB 4'h7
`define ACRB_EMPH_6DB 4'hC
`define ACRB_EMPH_7DB 4'hD
`define ACRB_EMPH_8DB 4'hF

`endif

// ### verilog/acrb_pkg.sv
// Purpose: shared types and the rate-pin slot decode
// Assumes: nothing
// Notes: numbers live in acrb_map.svh
package acrb_pkg;

    // slot chosen by the two rate pins
    typedef enum logic [1:0] {
        ACRB_SLOT_A = 2'h0,
        ACRB_SLOT_B = 2'h1,
        ACRB_SLOT_C = 2'h3,
        ACRB_SLOT_D = 2'h2
    } acrb_slot_t;

    // output amplitude setting
    typedef enum logic [1:0] {
        ACRB_SWING_300 = 2'h0,
        ACRB_SWING_600 = 2'h1,
        ACRB_SWING_900 = 2'h3
    } acrb_swing_t;

    // pin pair to slot; floating pins are pulled to the 10 pattern on the board
    function automatic acrb_slot_t acrb_slot_of(input logic hi, input logic lo);
        case ({hi, lo})
            2'h0: return ACRB_SLOT_A;
            2'h1: return ACRB_SLOT_B;
            2'h3: return ACRB_SLOT_C;
            default: return ACRB_SLOT_D;
        endcase
    endfunction

endpackage

// ### verilog/acrb_if.sv
// Purpose: carries slot registers and selection between the bank and the slot selector
// Assumes: both ends on clk
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface acrb_if;
    import acrb_pkg::*;
    logic [3:0][7:0] bw_slot;   // bandwidth slot registers a..d
    logic [3:0][7:0] lvl_slot;  // level slot registers a..d
    acrb_slot_t slot;           // slot in effect
    logic [3:0] active_bw;      // bandwidth code after substitution
    logic [6:0] active_lvl;     // level code after substitution
    modport bank (output bw_slot, output lvl_slot, output slot, input active_bw, input active_lvl);
    modport sel (input bw_slot, input lvl_slot, input slot, output active_bw, output active_lvl);
endinterface
`default_nettype wire

// ### verilog/acrb_slot_sel.sv
// Purpose: picks the slot in effect and substitutes fixed defaults
// Assumes: slot already synchronised
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "acrb_map.svh"
module acrb_slot_sel (
    // slot registers and results
    acrb_if.sel bus
);
    import acrb_pkg::*;

    // fixed bandwidth code of a slot
    function automatic logic [3:0] bw_default(input acrb_slot_t s);
        case (s)
            ACRB_SLOT_A: return `ACRB_BW_DEF_A;
            ACRB_SLOT_B: return `ACRB_BW_DEF_B;
            ACRB_SLOT_C: return `ACRB_BW_DEF_C;
            default: return `ACRB_BW_DEF_D;
        endcase
    endfunction

    // fixed level code of a slot, c and d share one
    function automatic logic [6:0] lvl_default(input acrb_slot_t s);
        case (s)
            ACRB_SLOT_A: return `ACRB_LVL_DEF_A;
            ACRB_SLOT_B: return `ACRB_LVL_DEF_B;
            default: return `ACRB_LVL_DEF_CD;
        endcase
    endfunction

    // register position of a slot; the pin codes run a, b, c, d in gray order
    function automatic logic [1:0] slot_pos(input acrb_slot_t s);
        return {s[1], s[1] ^ s[0]};
    endfunction

    logic [7:0] bw_raw;  // bandwidth register of the slot in effect
    logic [7:0] lvl_raw; // level register of the slot in effect

    // register code when its select bit is set, fixed default otherwise
    always_comb begin
        bw_raw = bus.bw_slot[slot_pos(bus.slot)];
        lvl_raw = bus.lvl_slot[slot_pos(bus.slot)];
        if (bw_raw[`ACRB_BIT_USE_REG]) begin
            bus.active_bw = bw_raw[3:0];
        end else begin
            bus.active_bw = bw_default(bus.slot);
        end
        if (lvl_raw[`ACRB_BIT_USE_REG]) begin
            bus.active_lvl = lvl_raw[6:0];
        end else begin
            bus.active_lvl = lvl_default(bus.slot);
        end
    end
endmodule
`default_nettype wire

// ### verilog/acrb_ctrl_bank.sv
// Purpose: control register bank of a rate-selectable limiting amplifier
// Assumes: a serial engine on link_clk presents decoded byte accesses
// Notes: registers live on clk; accesses cross by toggle handshake
//
// Contract
// - control bit 3 turns data output off
// - control bit 2 picks high loss range
// - control bit 1 turns offset nulling off
// - control bit 0 disables serial port, default 0
// - slice code 128 zero, below positive, above negative; code 0 gives zero shift
// - emphasis codes map to 0..8 dB
// - swing 00 300, 01/10 600, 11 900 mVpp
// - bandwidth slot bit 7 selects register code
// - bandwidth defaults 2.2, 4.0, 6.5, 11.0 GHz
// - rate pins 00 A, 01 B, 11 C, else D
// - level slot bit 7 selects 7-bit code
// - level defaults 15, 18, 26, 26 mVpp
// - level slot follows the same pin decode
// - read-only report of bandwidth code in effect
// - read-only report of level code in effect
// - offsets 0..11 writable, 14 and 15 reports
`timescale 1ns/1ps
`default_nettype none
`include "acrb_map.svh"
module acrb_ctrl_bank (
    // system clock and reset
    input wire logic clk,
    input wire logic rst,
    // link side, on link_clk
    input wire logic link_clk,
    input wire logic lk_req,
    input wire logic lk_we,
    input wire logic [3:0] lk_addr,
    input wire logic [7:0] lk_wdata,
    output logic [7:0] lk_rdata,
    output logic lk_done,
    output logic lk_busy,
    // rate pins
    input wire logic band_pin_hi,
    input wire logic band_pin_lo,
    // analog controls
    output logic output_off,
    output logic no_signal_range_high,
    output logic offset_null_off,
    output logic serial_port_off,
    output logic [7:0] slice_shift_code,
    output logic slice_shift_neg,
    output logic [6:0] slice_shift_mag,
    output logic [3:0] emphasis_code,
    output logic [3:0] emphasis_db,
    output acrb_pkg::acrb_swing_t swing_level,
    output logic [3:0] active_bw_code,
    output logic [6:0] active_level_code
);
    import acrb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // writable bits of an address
    function automatic logic [7:0] wmask(input logic [3:0] a);
        if (a == `ACRB_ADDR_CTRL) begin
            return `ACRB_MASK_CTRL;
        end else if (a == `ACRB_ADDR_SLICE) begin
            return `ACRB_MASK_SLICE;
        end else if (a == `ACRB_ADDR_EMPH) begin
            return `ACRB_MASK_EMPH;
        end else if (a == `ACRB_ADDR_SWING) begin
            return `ACRB_MASK_SWING;
        end else if (a < `ACRB_ADDR_LVL_A) begin
            return `ACRB_MASK_BW;
        end else begin
            return `ACRB_MASK_LVL;
        end
    endfunction

    // emphasis code to dB; unlisted codes take the next lower listed step
    function automatic logic [3:0] emph_to_db(input logic [3:0] c);
        if (c >= `ACRB_EMPH_8DB) begin
            return 4'h8;
        end else if (c >= `ACRB_EMPH_7DB) begin
            return 4'h7;
        end else if (c >= `ACRB_EMPH_6DB) begin
            return 4'h6;
        end else if (c >= `ACRB_EMPH_5DB) begin
            return 4'h5;
        end else if (c >= `ACRB_EMPH_4DB) begin
            return 4'h4;
        end else if (c >= `ACRB_EMPH_3DB) begin
            return 4'h3;
        end else if (c >= `ACRB_EMPH_2DB) begin
            return 4'h2;
        end else if (c >= `ACRB_EMPH_1DB) begin
            return 4'h1;
        end else begin
            return 4'h0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: request capture and answer

    logic lr_s1_q, lr_s2_q;        // reset carried into the link domain
    logic req_tog_q;               // flips once per accepted request
    logic lk_we_q;                 // held write flag
    logic [3:0] lk_addr_q;         // held address
    logic [7:0] lk_wdata_q;        // held write data
    logic busy_q;                  // access in flight
    logic ak_s1_q, ak_s2_q, ak_s3_q; // answer toggle synchroniser
    logic done_q;                  // one link cycle per answer
    logic [7:0] rdata_lk_q;        // answer byte
    logic ack_tog_q;               // clk side answer toggle
    logic [7:0] rd_q;              // clk side read byte

    // reset synchroniser for the link side
    always_ff @(posedge link_clk) begin
        lr_s1_q <= rst;
        lr_s2_q <= lr_s1_q;
    end

    // accept one request while idle; hold its fields until the answer
    always_ff @(posedge link_clk) begin
        if (lr_s2_q) begin
            req_tog_q <= 1'b0;
            lk_we_q <= 1'b0;
            lk_addr_q <= 4'h0;
            lk_wdata_q <= `ACRB_RESET_BYTE;
        end else if (lk_req && !busy_q) begin
            req_tog_q <= ~req_tog_q;
            lk_we_q <= lk_we;
            lk_addr_q <= lk_addr;
            lk_wdata_q <= lk_wdata;
        end
    end

    // answer toggle synchroniser
    always_ff @(posedge link_clk) begin
        if (lr_s2_q) begin
            ak_s1_q <= 1'b0;
            ak_s2_q <= 1'b0;
            ak_s3_q <= 1'b0;
        end else begin
            ak_s1_q <= ack_tog_q;
            ak_s2_q <= ak_s1_q;
            ak_s3_q <= ak_s2_q;
        end
    end

    // busy, done pulse and read byte
    always_ff @(posedge link_clk) begin
        if (lr_s2_q) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rdata_lk_q <= `ACRB_RESET_BYTE;
        end else begin
            done_q <= ak_s2_q ^ ak_s3_q;
            if (ak_s2_q ^ ak_s3_q) begin
                busy_q <= 1'b0;
                rdata_lk_q <= rd_q;
            end else if (lk_req) begin
                busy_q <= 1'b1;
            end
        end
    end

    assign lk_busy = busy_q;
    assign lk_done = done_q;
    assign lk_rdata = rdata_lk_q;

    ////////////////////////////////////////////////////////////////////////////////
    // clk domain: register access

    logic rq_s1_q, rq_s2_q, rq_s3_q;          // request toggle synchroniser
    logic rq_evt;                             // one clk per request
    logic [`ACRB_NUM_RW-1:0][7:0] regs_q;     // writable registers
    logic [7:0] read_byte;                    // read mux result
    logic wr_ok;                              // write takes effect

    // request toggle synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            rq_s1_q <= 1'b0;
            rq_s2_q <= 1'b0;
            rq_s3_q <= 1'b0;
        end else begin
            rq_s1_q <= req_tog_q;
            rq_s2_q <= rq_s1_q;
            rq_s3_q <= rq_s2_q;
        end
    end

    assign rq_evt = rq_s2_q ^ rq_s3_q;
    // port off blocks every write; reports and holes ignore writes
    assign wr_ok = rq_evt && lk_we_q && !regs_q[`ACRB_ADDR_CTRL][`ACRB_BIT_PORT_OFF]
        && (lk_addr_q <= `ACRB_ADDR_LAST_RW);

    // read mux: reports at 14 and 15, holes read zero
    always_comb begin
        if (lk_addr_q <= `ACRB_ADDR_LAST_RW) begin
            read_byte = regs_q[lk_addr_q];
        end else if (lk_addr_q == `ACRB_ADDR_BW_RPT) begin
            read_byte = {4'h0, active_bw_code};
        end else if (lk_addr_q == `ACRB_ADDR_LVL_RPT) begin
            read_byte = {1'b0, active_level_code};
        end else begin
            read_byte = `ACRB_RESET_BYTE;
        end
    end

    // register writes, masked to the assigned bits
    always_ff @(posedge clk) begin
        if (rst) begin
            regs_q <= '0;
        end else if (wr_ok) begin
            regs_q[lk_addr_q] <= lk_wdata_q & wmask(lk_addr_q);
        end
    end

    // read byte and answer toggle; a disabled port answers zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_q <= `ACRB_RESET_BYTE;
            ack_tog_q <= 1'b0;
        end else if (rq_evt) begin
            if (regs_q[`ACRB_ADDR_CTRL][`ACRB_BIT_PORT_OFF]) begin
                rd_q <= `ACRB_RESET_BYTE;
            end else begin
                rd_q <= read_byte;
            end
            ack_tog_q <= ~ack_tog_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // rate pins and slot selection

    logic [1:0] pin_s1_q, pin_s2_q; // pin synchroniser, hi then lo
    acrb_if sel_bus ();

    // two flops ahead of any decode
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
        end else begin
            pin_s1_q <= {band_pin_hi, band_pin_lo};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign sel_bus.slot = acrb_slot_of(pin_s2_q[1], pin_s2_q[0]);
    assign sel_bus.bw_slot = regs_q[`ACRB_ADDR_BW_A+3:`ACRB_ADDR_BW_A];
    assign sel_bus.lvl_slot = regs_q[`ACRB_ADDR_LVL_A+3:`ACRB_ADDR_LVL_A];

    acrb_slot_sel u_sel (
        .bus(sel_bus)
    );

    // codes in effect, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            active_bw_code <= 4'h0;
            active_level_code <= 7'h00;
        end else begin
            active_bw_code <= sel_bus.active_bw;
            active_level_code <= sel_bus.active_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // analog control decode

    // control bits straight from the register
    assign output_off = regs_q[`ACRB_ADDR_CTRL][`ACRB_BIT_OUT_OFF];
    assign no_signal_range_high = regs_q[`ACRB_ADDR_CTRL][`ACRB_BIT_RANGE_HI];
    assign offset_null_off = regs_q[`ACRB_ADDR_CTRL][`ACRB_BIT_NULL_OFF];
    assign serial_port_off = regs_q[`ACRB_ADDR_CTRL][`ACRB_BIT_PORT_OFF];
    assign slice_shift_code = regs_q[`ACRB_ADDR_SLICE];
    assign emphasis_code = regs_q[`ACRB_ADDR_EMPH][3:0];

    // slice sign and magnitude; code 0 is treated as zero shift
    always_ff @(posedge clk) begin
        if (rst) begin
            slice_shift_neg <= 1'b0;
            slice_shift_mag <= 7'h00;
        end else if (slice_shift_code > `ACRB_SLICE_ZERO) begin
            slice_shift_neg <= 1'b1;
            slice_shift_mag <= 7'(slice_shift_code - `ACRB_SLICE_ZERO);
        end else if (slice_shift_code == `ACRB_SLICE_ZERO || slice_shift_code == 8'h00) begin
            slice_shift_neg <= 1'b0;
            slice_shift_mag <= 7'h00;
        end else begin
            slice_shift_neg <= 1'b0;
            slice_shift_mag <= 7'(`ACRB_SLICE_ZERO - slice_shift_code);
        end
    end

    // emphasis step and swing level
    always_ff @(posedge clk) begin
        if (rst) begin
            emphasis_db <= 4'h0;
            swing_level <= ACRB_SWING_300;
        end else begin
            emphasis_db <= emph_to_db(emphasis_code);
            case (regs_q[`ACRB_ADDR_SWING][1:0])
                2'h0: swing_level <= ACRB_SWING_300;
                2'h3: swing_level <= ACRB_SWING_900;
                default: swing_level <= ACRB_SWING_600;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_out_off;
        @(posedge clk) disable iff (rst)
        wr_ok && lk_addr_q == `ACRB_ADDR_CTRL |=> output_off == $past(lk_wdata_q[3]);
    endproperty
    a_out_off: assert property (p_out_off) else $error("output off not set by write");

    property p_range_null;
        @(posedge clk) disable iff (rst)
        wr_ok && lk_addr_q == `ACRB_ADDR_CTRL
            |=> no_signal_range_high == $past(lk_wdata_q[2]) && offset_null_off == $past(lk_wdata_q[1]);
    endproperty
    a_range_null: assert property (p_range_null) else $error("range or null bit wrong");

    property p_port_off;
        @(posedge clk) disable iff (rst)
        rq_evt && serial_port_off |=> rd_q == `ACRB_RESET_BYTE && $stable(regs_q);
    endproperty
    a_port_off: assert property (p_port_off) else $error("disabled port still served");

    property p_slice;
        @(posedge clk) disable iff (rst)
        slice_shift_code > `ACRB_SLICE_ZERO ##1 $stable(slice_shift_code)
            |-> slice_shift_neg && slice_shift_mag == 7'(slice_shift_code - `ACRB_SLICE_ZERO);
    endproperty
    a_slice: assert property (p_slice) else $error("negative slice decode wrong");

    property p_emph;
        @(posedge clk) disable iff (rst)
        emphasis_code == `ACRB_EMPH_5DB |=> emphasis_db == 4'h5;
    endproperty
    a_emph: assert property (p_emph) else $error("emphasis step wrong");

    property p_swing;
        @(posedge clk) disable iff (rst)
        regs_q[`ACRB_ADDR_SWING][1] != regs_q[`ACRB_ADDR_SWING][0] |=> swing_level == ACRB_SWING_600;
    endproperty
    a_swing: assert property (p_swing) else $error("mid swing not selected");

    property p_bw_reg;
        @(posedge clk) disable iff (rst)
        sel_bus.bw_slot[{pin_s2_q[1], ^pin_s2_q}][`ACRB_BIT_USE_REG]
            |=> active_bw_code == $past(sel_bus.bw_slot[{pin_s2_q[1], ^pin_s2_q}][3:0]);
    endproperty
    a_bw_reg: assert property (p_bw_reg) else $error("bandwidth register code not used");

    property p_slot_a;
        @(posedge clk) disable iff (rst)
        pin_s2_q == 2'h0 && !sel_bus.bw_slot[0][`ACRB_BIT_USE_REG] |=> active_bw_code == `ACRB_BW_DEF_A;
    endproperty
    a_slot_a: assert property (p_slot_a) else $error("slot a default not applied");

    property p_lvl_d;
        @(posedge clk) disable iff (rst)
        pin_s2_q == 2'h2 && sel_bus.lvl_slot[3][`ACRB_BIT_USE_REG]
            |=> active_level_code == $past(sel_bus.lvl_slot[3][6:0]);
    endproperty
    a_lvl_d: assert property (p_lvl_d) else $error("slot d level not applied");

    property p_report_ro;
        @(posedge clk) disable iff (rst)
        rq_evt && lk_we_q && lk_addr_q >= `ACRB_ADDR_BW_RPT |=> $stable(regs_q);
    endproperty
    a_report_ro: assert property (p_report_ro) else $error("report write changed state");

    property p_mask;
        @(posedge clk) disable iff (rst)
        wr_ok && lk_addr_q == `ACRB_ADDR_SWING
            |=> regs_q[`ACRB_ADDR_SWING] == ($past(lk_wdata_q) & `ACRB_MASK_SWING);
    endproperty
    a_mask: assert property (p_mask) else $error("unassigned bits stored");

    property p_reset;
        @(posedge clk) rst |=> regs_q == '0 && !output_off && !serial_port_off;
    endproperty
    a_reset: assert property (p_reset) else $error("registers not cleared");
endmodule
`default_nettype wire

// ### verif/acrb_host_model.sv
// Purpose: link-side requester that feeds byte accesses to the control bank
// Assumes: one access at a time, answered by a one-cycle done pulse
// Notes: released address and data lines carry the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module acrb_host_model (
    // link clock and answer
    input wire logic link_clk,
    input wire logic lk_done,
    input wire logic [7:0] lk_rdata,
    // request lines
    output logic lk_req,
    output logic lk_we,
    output logic [3:0] lk_addr,
    output logic [7:0] lk_wdata
);
    // idle lines at time zero
    initial begin
        lk_req = 1'b0;
        lk_we = 1'b0;
        lk_addr = 4'h0;
        lk_wdata = 8'h00;
    end

    // one access: hold write flag, address and data until done is sampled, then release address and data
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge link_clk);
        lk_req <= 1'b1;
        lk_we <= w;
        lk_addr <= a;
        lk_wdata <= d;
        // taken at the next edge while idle; drop it there so it is not taken twice
        @(posedge link_clk);
        lk_req <= 1'b0;
        do begin
            @(posedge link_clk);
            n++;
        end while (lk_done !== 1'b1 && n < 20);
        ok = (lk_done === 1'b1);
        q = lk_rdata;
        lk_req <= 1'b0;
        lk_addr <= ~a;
        lk_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### verif/acrb_ctrl_bank_bench.sv
// Purpose: self-checking bench of the amplifier control bank
// Assumes: host model on link_clk, rate pins driven on clk
// Notes: serial port disable runs last, only reset clears it
`timescale 1ns/1ps
`default_nettype none
`include "acrb_map.svh"
module acrb_ctrl_bank_bench;
    import acrb_pkg::*;
    logic clk = 0, link_clk = 0, rst = 1, hi = 0, lo = 0;
    logic req, we, done, busy, o_off, rng, nul, poff, neg, ok;
    logic [3:0] addr, emc, db, abw;
    logic [7:0] wd, rd, slc, q;
    logic [6:0] mag, alv;
    acrb_swing_t sw;
    int errors = 0, compares = 0;

    // clocks, link clock offset in phase
    always #25 clk = ~clk;
    initial begin
        #13;
        forever #40 link_clk = ~link_clk;
    end

    acrb_ctrl_bank DUT (.clk(clk), .rst(rst), .link_clk(link_clk), .lk_req(req),
        .lk_we(we), .lk_addr(addr), .lk_wdata(wd), .lk_rdata(rd), .lk_done(done),
        .lk_busy(busy), .band_pin_hi(hi), .band_pin_lo(lo), .output_off(o_off),
        .no_signal_range_high(rng), .offset_null_off(nul), .serial_port_off(poff),
        .slice_shift_code(slc), .slice_shift_neg(neg), .slice_shift_mag(mag),
        .emphasis_code(emc), .emphasis_db(db), .swing_level(sw),
        .active_bw_code(abw), .active_level_code(alv));
    acrb_host_model host (.link_clk(link_clk), .lk_done(done), .lk_rdata(rd),
        .lk_req(req), .lk_we(we), .lk_addr(addr), .lk_wdata(wd));

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // every access must be answered in time and leave the link idle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, q, ok);
        chk("link", 8'h01, {6'h0, busy, ok});
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 8'h00, q, ok);
        chk("link", 8'h01, {6'h0, busy, ok});
        chk("rdata", e, q);
    endtask
    // let registered outputs land
    task automatic settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        for (int a = 0; a < 12; a++) rdc(a[3:0], 8'h00);
        wr(4'hC, 8'hAA);
        rdc(4'hC, 8'h00);
        rdc(4'hE, {4'h0, `ACRB_BW_DEF_A});
        rdc(4'hF, {1'b0, `ACRB_LVL_DEF_A});
    endtask
    task automatic t_ctrl;
        wr(4'h0, 8'hFE);
        settle;
        chk("ctrl", 8'h0E, {4'h0, o_off, rng, nul, poff});
        rdc(4'h0, 8'h0E);
        wr(4'h0, 8'h00);
        settle;
        chk("ctrl", 8'h00, {4'h0, o_off, rng, nul, poff});
    endtask
    task automatic t_slice;
        logic [7:0] c [5] = '{8'h01, 8'h7F, 8'h80, 8'h81, 8'hFF};
        foreach (c[i]) begin
            wr(4'h1, c[i]);
            settle;
            chk("shift", c[i] > 8'h80 ? {1'b1, c[i][6:0]} : 8'h80 - c[i], {neg, mag});
        end
    endtask
    task automatic t_emph;
        logic [3:0] c [9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'hC, 4'hD, 4'hF};
        foreach (c[i]) begin
            wr(4'h2, {4'hF, c[i]});
            settle;
            chk("db", {4'h0, 4'(i)}, {4'h0, db});
            chk("emc", {4'h0, c[i]}, {4'h0, emc});
        end
        rdc(4'h2, 8'h0F);
    endtask
    task automatic t_swing;
        for (int i = 0; i < 4; i++) begin
            wr(4'h3, 8'hFC | 8'(i));
            settle;
            chk("swing", i == 0 ? 8'h00 : i == 3 ? 8'h03 : 8'h01, {6'h0, sw});
        end
        rdc(4'h3, 8'h03);
    endtask
    // each pin pattern: default, register code, then select cleared again
    task automatic t_slots;
        logic [1:0] p [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        logic [3:0] b [4] = '{`ACRB_BW_DEF_A, `ACRB_BW_DEF_B, `ACRB_BW_DEF_C, `ACRB_BW_DEF_D};
        logic [6:0] l [4] = '{`ACRB_LVL_DEF_A, `ACRB_LVL_DEF_B, `ACRB_LVL_DEF_CD,
                              `ACRB_LVL_DEF_CD};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {hi, lo} <= p[i];
            settle;
            chk("bw", {4'h0, b[i]}, {4'h0, abw});
            chk("lvl", {1'b0, l[i]}, {1'b0, alv});
            wr(4'h4 + 4'(i), 8'hF6 + 8'(i));
            wr(4'h8 + 4'(i), 8'hC0 + 8'(i));
            wr(4'hE, 8'hFF);
            wr(4'hF, 8'hFF);
            settle;
            rdc(4'hE, 8'h06 + 8'(i));
            rdc(4'hF, 8'h40 + 8'(i));
            rdc(4'h4 + 4'(i), 8'h86 + 8'(i));
            wr(4'h4 + 4'(i), 8'h06);
            wr(4'h8 + 4'(i), 8'h40);
            settle;
            chk("bw", {4'h0, b[i]}, {4'h0, abw});
            chk("lvl", {1'b0, l[i]}, {1'b0, alv});
        end
    endtask
    task automatic t_port_off;
        wr(4'h1, 8'h80);
        wr(4'h0, 8'h01);
        settle;
        chk("port", 8'h01, {7'h0, poff});
        wr(4'h1, 8'h33);
        rdc(4'h1, 8'h00);
        settle;
        chk("slice", 8'h80, slc);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict and run
    task automatic results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge link_clk);
        t_reset;
        t_ctrl;
        t_slice;
        t_emph;
        t_swing;
        t_slots;
        t_port_off;
        results;
    end
    // watchdog against a hung handshake
    initial begin
        #400000;
        errors++;
        results;
    end
endmodule
`default_nettype wire
